// ### afpcc_defines.vh
`ifndef AFPCC_DEFINES_VH
`define AFPCC_DEFINES_VH

// register page and offsets
`define AFPCC_PAGE0 8'h00
`define AFPCC_OFS_PLL_EN 7'h04
`define AFPCC_OFS_REF_SEL 7'h0D
`define AFPCC_OFS_PRE_DIV 7'h14
`define AFPCC_OFS_INT_MUL 7'h15
`define AFPCC_OFS_FRAC_HI 7'h16
`define AFPCC_OFS_FRAC_LO 7'h17
`define AFPCC_OFS_POST_MUL 7'h18
`define AFPCC_OFS_PROC_DIV 7'h1B
`define AFPCC_OFS_BCK_DIV 7'h20
`define AFPCC_OFS_FRM_DIV 7'h21

// field positions
`define AFPCC_EN_BIT 0
`define AFPCC_REF_MSB 6
`define AFPCC_REF_LSB 4
`define AFPCC_PRE_MSB 3
`define AFPCC_INT_MSB 5
`define AFPCC_FRH_MSB 5
`define AFPCC_POST_MSB 3
`define AFPCC_DIV7_MSB 6
`define AFPCC_DIV8_MSB 7

// reset values
`define AFPCC_RST_EN 1'h1
`define AFPCC_RST_REF 3'h0
`define AFPCC_RST_PRE 4'h0
`define AFPCC_RST_INT 6'h08
`define AFPCC_RST_FRH 6'h00
`define AFPCC_RST_FRL 8'h00
`define AFPCC_RST_POST 4'h0
`define AFPCC_RST_PROC 7'h01
`define AFPCC_RST_BCK 7'h07
`define AFPCC_RST_FRM 8'h3F

// reference source codes
`define AFPCC_REF_MCLK 3'h0
`define AFPCC_REF_BCLK 3'h1
`define AFPCC_REF_GPIO 3'h3

// fraction scale (four decimal digits) and sample divider
`define AFPCC_FRAC_SCALE 14'h2710
`define AFPCC_FS_LAST 11'h7FF

// master clock to frame ratios
`define AFPCC_RATIO_128 10'h080
`define AFPCC_RATIO_192 10'h0C0
`define AFPCC_RATIO_256 10'h100
`define AFPCC_RATIO_384 10'h180
`define AFPCC_RATIO_512 10'h200
`define AFPCC_RATIO_MAX 10'h3FF

`endif

// ### afpcc_clock_config.v
// Overview of operation
// - pll reference may be master clock, bit clock or a general-purpose pin
// - three-bit reference select field sits in page 0 register 13 bits 6:4
// - pll enable bit zero bypasses the pll; master clock must then be supplied
// - pll comes out of reset enabled and running without software writes
// - output clock equals input clock times R times K divided by P
// - R programmable 1 to 16, P programmable 1 to 16
// - J is integer part of K, D is four-digit fraction 0000 to 9999
// - sample rate is vco frequency divided by 2048 while pll enabled
// - P, J, D and R coefficients live in page 0 registers 20 to 24
// - processing, bit clock and frame clock dividers in registers 27, 32, 33
// - pll reference works from 1 to 50 MHz with fine coefficient precision
// - a master clock of 64 times the sample rate is never supported
// - 128 and 192 ratios need the pll; 256, 384, 512 work directly
`timescale 1ns/1ps
`include "afpcc_defines.vh"

module afpcc_clock_config #(
    parameter CREDIT_W = 28
) (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_n_in,
    // register port
    input wire [7:0] reg_page_in,
    input wire [6:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    // audio clock inputs
    input wire master_clock_in,
    input wire bit_clock_in,
    input wire frame_clock_in,
    input wire gpio_ref_in,
    // derived clock ticks
    output reg pll_output_clock_out,
    output reg processing_tick_out,
    output reg bit_clock_tick_out,
    output reg frame_clock_tick_out,
    output reg sample_tick_out,
    // status
    output reg pll_active_out,
    output reg ratio_ok_out
);

    // software-visible fields
    reg pll_enable_field;
    reg [2:0] pll_ref_field;
    reg [3:0] pre_divide_field;
    reg [5:0] integer_mult_field;
    reg [5:0] fraction_hi_field;
    reg [7:0] fraction_lo_field;
    reg [3:0] post_mult_field;
    reg [6:0] processing_div_field;
    reg [6:0] bit_clock_div_field;
    reg [7:0] frame_clock_div_field;

    // coefficients the generator actually uses
    reg [3:0] act_p;
    reg [5:0] act_j;
    reg [13:0] act_d;
    reg [3:0] act_r;

    reg [7:0] rd_mux;
    reg ref_lvl;
    reg ref_prev;
    reg mclk_prev;
    reg frame_prev;
    reg [CREDIT_W-1:0] credit;
    reg [CREDIT_W-1:0] next_credit;
    reg [10:0] fs_cnt;
    reg [9:0] ratio_cnt;

    wire page_hit = (reg_page_in == `AFPCC_PAGE0);
    wire wr_hit = reg_wr_in && page_hit;
    wire ref_rise = ref_lvl && !ref_prev;
    wire mclk_rise = master_clock_in && !mclk_prev;
    wire frame_rise = frame_clock_in && !frame_prev;

    // true when a master clock to frame ratio can run in the given mode
    function ratio_ok;
        input [9:0] n;
        input pll_on;
        begin
            case (n)
                `AFPCC_RATIO_256, `AFPCC_RATIO_384, `AFPCC_RATIO_512: ratio_ok = 1'b1;
                `AFPCC_RATIO_128, `AFPCC_RATIO_192: ratio_ok = pll_on;
                default: ratio_ok = 1'b0;
            endcase
        end
    endfunction

    // register writes
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pll_enable_field <= `AFPCC_RST_EN;
            pll_ref_field <= `AFPCC_RST_REF;
            pre_divide_field <= `AFPCC_RST_PRE;
            integer_mult_field <= `AFPCC_RST_INT;
            fraction_hi_field <= `AFPCC_RST_FRH;
            fraction_lo_field <= `AFPCC_RST_FRL;
            post_mult_field <= `AFPCC_RST_POST;
            processing_div_field <= `AFPCC_RST_PROC;
            bit_clock_div_field <= `AFPCC_RST_BCK;
            frame_clock_div_field <= `AFPCC_RST_FRM;
        end else if (wr_hit) begin
            // writes land even while the pll runs; the shadow copy decides when P, J, D and R
            // start to count, so software may stage a full coefficient set in advance
            case (reg_addr_in)
                `AFPCC_OFS_PLL_EN: begin
                    pll_enable_field <= reg_wdata_in[`AFPCC_EN_BIT];
                end
                `AFPCC_OFS_REF_SEL: begin
                    pll_ref_field <= reg_wdata_in[`AFPCC_REF_MSB:`AFPCC_REF_LSB];
                end
                `AFPCC_OFS_PRE_DIV: begin
                    pre_divide_field <= reg_wdata_in[`AFPCC_PRE_MSB:0];
                end
                `AFPCC_OFS_INT_MUL: begin
                    integer_mult_field <= reg_wdata_in[`AFPCC_INT_MSB:0];
                end
                `AFPCC_OFS_FRAC_HI: begin
                    // upper six bits of the one binary fraction word
                    fraction_hi_field <= reg_wdata_in[`AFPCC_FRH_MSB:0];
                end
                `AFPCC_OFS_FRAC_LO: begin
                    fraction_lo_field <= reg_wdata_in;
                end
                `AFPCC_OFS_POST_MUL: begin
                    post_mult_field <= reg_wdata_in[`AFPCC_POST_MSB:0];
                end
                `AFPCC_OFS_PROC_DIV: begin
                    processing_div_field <= reg_wdata_in[`AFPCC_DIV7_MSB:0];
                end
                `AFPCC_OFS_BCK_DIV: begin
                    bit_clock_div_field <= reg_wdata_in[`AFPCC_DIV7_MSB:0];
                end
                `AFPCC_OFS_FRM_DIV: begin
                    frame_clock_div_field <= reg_wdata_in[`AFPCC_DIV8_MSB:0];
                end
                default: begin
                    // unmapped offsets are dropped with no error indication
                end
            endcase
        end
    end

    // read mux; unmapped offsets and other pages read zero
    always @* begin
        rd_mux = 8'h00;
        if (page_hit) begin
            // reserved bits read zero so software may write back what it read
            case (reg_addr_in)
                `AFPCC_OFS_PLL_EN: begin
                    rd_mux = {7'h00, pll_enable_field};
                end
                `AFPCC_OFS_REF_SEL: begin
                    rd_mux = {1'b0, pll_ref_field, 4'h0};
                end
                `AFPCC_OFS_PRE_DIV: begin
                    rd_mux = {4'h0, pre_divide_field};
                end
                `AFPCC_OFS_INT_MUL: begin
                    rd_mux = {2'h0, integer_mult_field};
                end
                `AFPCC_OFS_FRAC_HI: begin
                    rd_mux = {2'h0, fraction_hi_field};
                end
                `AFPCC_OFS_FRAC_LO: begin
                    rd_mux = fraction_lo_field;
                end
                `AFPCC_OFS_POST_MUL: begin
                    rd_mux = {4'h0, post_mult_field};
                end
                `AFPCC_OFS_PROC_DIV: begin
                    rd_mux = {1'b0, processing_div_field};
                end
                `AFPCC_OFS_BCK_DIV: begin
                    rd_mux = {1'b0, bit_clock_div_field};
                end
                `AFPCC_OFS_FRM_DIV: begin
                    rd_mux = frame_clock_div_field;
                end
                default: begin
                    rd_mux = 8'h00;
                end
            endcase
        end
    end

    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // shadow copy follows software only while the pll is off, so a running
    // output never sees a half-written coefficient set
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            act_p <= `AFPCC_RST_PRE;
            act_j <= `AFPCC_RST_INT;
            act_d <= {`AFPCC_RST_FRH, `AFPCC_RST_FRL};
            act_r <= `AFPCC_RST_POST;
        end else if (!pll_enable_field) begin
            act_p <= pre_divide_field;
            act_j <= integer_mult_field;
            act_d <= {fraction_hi_field, fraction_lo_field};
            act_r <= post_mult_field;
        end
    end

    // reference source mux; limits on its frequency are the source's duty
    always @* begin
        case (pll_ref_field)
            `AFPCC_REF_MCLK: ref_lvl = master_clock_in;
            `AFPCC_REF_BCLK: ref_lvl = bit_clock_in;
            `AFPCC_REF_GPIO: ref_lvl = gpio_ref_in;
            default: ref_lvl = master_clock_in;
        endcase
    end

    // field codes n stand for values n+1
    wire [4:0] p_val = {1'b0, act_p} + 5'h01;
    wire [4:0] r_val = {1'b0, act_r} + 5'h01;
    // K scaled by ten thousand, then times R; P times ten thousand
    wire [19:0] k_x = ({14'h0000, act_j} * {6'h00, `AFPCC_FRAC_SCALE}) + {6'h00, act_d};
    wire [24:0] m_x = {5'h00, k_x} * {20'h00000, r_val};
    wire [18:0] p_x = {14'h0000, p_val} * {5'h00, `AFPCC_FRAC_SCALE};
    wire [CREDIT_W-1:0] m_ext = {{(CREDIT_W-25){1'b0}}, m_x};
    wire [CREDIT_W-1:0] p_ext = {{(CREDIT_W-19){1'b0}}, p_x};
    // limitation: at most one output tick per system clock, so a real vco
    // rate is only modelled at reduced scale
    wire emit = (credit >= p_ext);
    wire pll_tick = pll_enable_field ? emit : mclk_rise;

    // fractional rate generator: R*K/P ticks per reference edge on average
    always @* begin
        next_credit = credit;
        if (ref_rise) begin
            next_credit = next_credit + m_ext;
        end
        if (emit) begin
            next_credit = next_credit - p_ext;
        end
    end

    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            credit <= {CREDIT_W{1'b0}};
            ref_prev <= 1'b0;
            mclk_prev <= 1'b0;
            frame_prev <= 1'b0;
        end else begin
            credit <= pll_enable_field ? next_credit : {CREDIT_W{1'b0}};
            ref_prev <= ref_lvl;
            mclk_prev <= master_clock_in;
            frame_prev <= frame_clock_in;
        end
    end

    // three dividers: processing and bit clock from the pll tick,
    // frame clock from the bit clock tick
    wire [7:0] div_lim [0:2];
    wire [2:0] div_src;
    wire [2:0] div_hit;
    assign div_lim[0] = {1'b0, processing_div_field};
    assign div_lim[1] = {1'b0, bit_clock_div_field};
    assign div_lim[2] = frame_clock_div_field;
    assign div_src = {div_hit[1], pll_tick, pll_tick};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_div
            reg [7:0] cnt;
            assign div_hit[gi] = div_src[gi] && (cnt >= div_lim[gi]);
            always @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    cnt <= 8'h00;
                end else if (div_src[gi]) begin
                    cnt <= div_hit[gi] ? 8'h00 : cnt + 8'h01;
                end
            end
        end
    endgenerate

    // sample tick, frame ratio check and registered outputs
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fs_cnt <= 11'h000;
            ratio_cnt <= 10'h000;
            pll_output_clock_out <= 1'b0;
            processing_tick_out <= 1'b0;
            bit_clock_tick_out <= 1'b0;
            frame_clock_tick_out <= 1'b0;
            sample_tick_out <= 1'b0;
            pll_active_out <= 1'b0;
            ratio_ok_out <= 1'b0;
        end else begin
            if (!pll_enable_field) begin
                fs_cnt <= 11'h000;
            end else if (pll_tick) begin
                fs_cnt <= fs_cnt + 11'h001;
            end
            sample_tick_out <= pll_enable_field && pll_tick
                && (fs_cnt == `AFPCC_FS_LAST);
            // the ratio counter saturates, so after a stopped frame clock the next frame edge
            // reads as an unsupported ratio rather than wrapping into a legal one;
            // an mclk edge in the frame edge cycle opens the next count
            if (frame_rise) begin
                ratio_ok_out <= ratio_ok(ratio_cnt, pll_enable_field);
                ratio_cnt <= mclk_rise ? 10'h001 : 10'h000;
            end else if (mclk_rise && ratio_cnt != `AFPCC_RATIO_MAX) begin
                ratio_cnt <= ratio_cnt + 10'h001;
            end
            pll_output_clock_out <= pll_tick;
            processing_tick_out <= div_hit[0];
            bit_clock_tick_out <= div_hit[1];
            frame_clock_tick_out <= div_hit[2];
            pll_active_out <= pll_enable_field;
        end
    end

endmodule // afpcc_clock_config

// ### afpcc_assertions.sv
`timescale 1ns/1ps
module afpcc_assertions (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_n_in,
    // register port
    input wire [7:0] reg_page_in,
    input wire [6:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    // clocks
    input wire master_clock_in,
    input wire pll_output_clock_out,
    input wire pll_active_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire rd0 = reg_rd_in && reg_page_in == 8'h00;
    en_mirror_a: assert property (
        reg_wr_in && reg_page_in == 8'h00 && reg_addr_in == 7'h04
        |-> ##2 pll_active_out == $past(reg_wdata_in[0], 2)) else $error("enable not mirrored");
    page_a: assert property (
        reg_rd_in && reg_page_in != 8'h00 |-> ##2 reg_rdata_out == 8'h00) else $error("page read");
    hole_a: assert property (
        rd0 && reg_addr_in == 7'h05 |-> ##2 reg_rdata_out == 8'h00) else $error("hole read");
    en_resv_a: assert property (
        rd0 && reg_addr_in == 7'h04 |-> ##2 reg_rdata_out[7:1] == 7'h00) else $error("enable bits");
    ref_resv_a: assert property (
        rd0 && reg_addr_in == 7'h0D |-> ##2 !reg_rdata_out[7] && reg_rdata_out[3:0] == 4'h0)
        else $error("ref bits");
    j_resv_a: assert property (
        rd0 && reg_addr_in == 7'h15 |-> ##2 reg_rdata_out[7:6] == 2'h0) else $error("J bits");
    hold_a: assert property (
        !reg_rd_in && !$past(reg_rd_in) |=> $stable(reg_rdata_out)) else $error("rdata moved");
    bypass_a: assert property (
        !pll_active_out && $rose(master_clock_in)
        |-> ##[1:2] (pll_output_clock_out || pll_active_out)) else $error("bypass tick");
endmodule // afpcc_assertions

bind afpcc_clock_config afpcc_assertions i_chk (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .reg_page_in(reg_page_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .master_clock_in(master_clock_in),
    .pll_output_clock_out(pll_output_clock_out), .pll_active_out(pll_active_out));

// ### afpcc_audio_src.sv
`timescale 1ns/1ps
module afpcc_audio_src (
    // frame length in master clock periods
    input wire [9:0] ratio_in,
    // clocks toward the device
    output reg master_clock_out,
    output reg bit_clock_out,
    output reg frame_clock_out,
    output reg gpio_ref_out
);
    // 24 ns period is no multiple of the system clock, so edges drift in phase
    integer n;
    initial begin
        n = 0;
        {master_clock_out, bit_clock_out, frame_clock_out, gpio_ref_out} = 4'h0;
        // odd start offset keeps every edge off a system clock edge, no race
        #1.3;
        forever begin
            #12;
            master_clock_out = ~master_clock_out;
            if (master_clock_out) begin
                n = n + 1;
                gpio_ref_out = n[0];
                bit_clock_out = n[1];
                frame_clock_out = (n % ratio_in) < (ratio_in / 2);
            end
        end
    end
endmodule // afpcc_audio_src

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg sys_clk_in, reset_n_in, wr_s, rd;
    reg [7:0] pg, wd, rv;
    reg [6:0] ad, a7;
    reg [9:0] ratio;
    wire mck, bck, fck, gck, plt, prt, btt, frt, smt, act, rok;
    wire [7:0] rdat;
    integer errors, checks, i, t, cnt [0:8], snap [0:8], mdl [0:127];
    localparam [79:0] OFS = 80'h040D14151617181B2021;
    localparam [79:0] RST = 80'h0100000800000001073F;
    localparam [79:0] MSK = 80'h01700F3F3FFF0F7F7FFF;
    localparam [59:0] RAT = 60'h100803010060200;
    afpcc_clock_config i_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_page_in(pg), .reg_addr_in(ad), .reg_wr_in(wr_s), .reg_rd_in(rd),
        .reg_wdata_in(wd), .reg_rdata_out(rdat), .master_clock_in(mck),
        .bit_clock_in(bck), .frame_clock_in(fck), .gpio_ref_in(gck),
        .pll_output_clock_out(plt), .processing_tick_out(prt),
        .bit_clock_tick_out(btt), .frame_clock_tick_out(frt),
        .sample_tick_out(smt), .pll_active_out(act), .ratio_ok_out(rok));
    afpcc_audio_src i_src (.ratio_in(ratio), .master_clock_out(mck),
        .bit_clock_out(bck), .frame_clock_out(fck), .gpio_ref_out(gck));
    always @(posedge mck) cnt[0] = cnt[0] + 1;
    always @(posedge bck) cnt[1] = cnt[1] + 1;
    always @(posedge gck) cnt[2] = cnt[2] + 1;
    always @(posedge fck) cnt[3] = cnt[3] + 1;
    always @(posedge sys_clk_in) begin
        cnt[4] = cnt[4] + plt;
        cnt[5] = cnt[5] + smt;
        cnt[6] = cnt[6] + btt;
        cnt[7] = cnt[7] + frt;
        cnt[8] = cnt[8] + prt;
    end
    task end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    function [31:0] near(input integer a, input integer b, input integer tol);
        near = (a - b <= tol) && (b - a <= tol);
    endfunction
    task wr(input [7:0] p, input [6:0] a, input [7:0] d);
        @(negedge sys_clk_in);
        {pg, ad, wd, wr_s} = {p, a, d, 1'b1};
        if (p == 8'h00)
            mdl[a] = d;
        @(negedge sys_clk_in);
        wr_s = 1'b0;
    endtask
    task rdx(input [7:0] p, input [6:0] a);
        @(negedge sys_clk_in);
        {pg, ad, rd} = {p, a, 1'b1};
        @(negedge sys_clk_in);
        rd = 1'b0;
        @(negedge sys_clk_in);
        rv = rdat;
    endtask
    task cfg(input [2:0] r, input [7:0] j, input [13:0] d, input [3:0] rr, input [3:0] p);
        wr(8'h00, 7'h0D, {1'b0, r, 4'h0});
        wr(8'h00, 7'h14, {4'h0, p});
        wr(8'h00, 7'h15, j);
        wr(8'h00, 7'h16, {2'h0, d[13:8]});
        wr(8'h00, 7'h17, d[7:0]);
        wr(8'h00, 7'h18, {4'h0, rr});
        wr(8'h00, 7'h1B, 8'h00);
        wr(8'h00, 7'h20, 8'h00);
        wr(8'h00, 7'h21, 8'h01);
    endtask
    // leaves the per-counter deltas of the window in snap
    task win(input integer cyc);
        for (t = 0; t < 9; t = t + 1)
            snap[t] = cnt[t];
        repeat (cyc) @(negedge sys_clk_in);
        for (t = 0; t < 9; t = t + 1)
            snap[t] = cnt[t] - snap[t];
    endtask
    task frames(input integer nf);
        integer lim, tgt;
        tgt = cnt[3] + nf;
        lim = 0;
        while (cnt[3] < tgt && lim < 10000) begin
            @(negedge sys_clk_in);
            lim = lim + 1;
        end
        if (lim == 10000) begin
            errors = errors + 1;
            end_sim;
        end
        repeat (4) @(negedge sys_clk_in);
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        {reset_n_in, wr_s, rd, pg, ad, wd} = 26'h0;
        ratio = 10'h100;
        {errors, checks} = 64'h0;
        for (t = 0; t < 128; t = t + 1)
            mdl[t] = 0;
        for (t = 0; t < 9; t = t + 1)
            cnt[t] = 0;
        void'($urandom(32'hAD2A));
        repeat (10) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        chk("active", act, 1);
        for (i = 0; i < 10; i = i + 1) begin
            a7 = OFS[78-8*i -: 7];
            mdl[a7] = RST[79-8*i -: 8];
            rdx(8'h00, a7);
            chk("reset value", rv, mdl[a7]);
        end
        $display("test reset done");
        rdx(8'h01, 7'h15);
        chk("page read", rv, 0);
        rdx(8'h00, 7'h05);
        chk("hole read", rv, 0);
        wr(8'h01, 7'h15, 8'($urandom));
        rdx(8'h00, 7'h15);
        chk("page write", rv, mdl[21]);
        for (i = 1; i < 10; i = i + 1) begin
            a7 = OFS[78-8*i -: 7];
            wr(8'h00, a7, 8'($urandom));
            rdx(8'h00, a7);
            chk("field", rv, mdl[a7] & MSK[79-8*i -: 8]);
        end
        $display("test registers done");
        wr(8'h00, 7'h04, 8'h00);
        // K of 4.5: a nonzero fraction keeps J within 4 to 11 and R at one
        cfg(3'h0, 8'h04, 14'h1388, 4'h0, 4'h0);
        win(2000);
        chk("bypass", near(snap[4], snap[0], 2), 1);
        wr(8'h00, 7'h04, 8'h01);
        win(10000);
        chk("pll ticks", near(snap[4], snap[0] * 9 / 2, 5), 1);
        chk("samples", near(snap[5] * 2048, snap[4], 2048), 1);
        chk("proc ticks", near(snap[8], snap[4], 2), 1);
        chk("frame ticks", near(snap[7] * 2, snap[6], 2), 1);
        wr(8'h00, 7'h15, 8'h06);
        win(2000);
        chk("held", near(snap[4], snap[0] * 9 / 2, 5), 1);
        $display("test pll done");
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h00, 7'h04, 8'h00);
            cfg(3'(i == 2 ? 3 : i), 8'h06, 14'h0000, 4'h1, 4'h3);
            wr(8'h00, 7'h04, 8'h01);
            win(3000);
            chk("ref", near(snap[4], snap[i] * 3, 4), 1);
        end
        $display("test sources done");
        for (i = 0; i < 12; i = i + 1) begin
            ratio = RAT[59-10*(i%6) -: 10];
            wr(8'h00, 7'h04, {7'h00, i < 6});
            frames(3);
            chk("ratio", rok, ratio >= 10'h100 || (i < 6 && ratio >= 10'h080));
        end
        $display("test ratios done");
        end_sim;
    end
endmodule // tb_top
